// ---- logic/chained_setup_serial_loader.sv ----
// setup word loader for a daisy chained repeater serial port
// =====================================================
`timescale 1ns/1ps
`include "loader_cfg.svh"

module chained_setup_serial_loader #(
  parameter int unsigned RESET_MIN_CYCLES = `RESET_MIN_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic hw_reset_i,
  input wire logic mgmt_mode_select_i,
  input wire logic chain_first_select_i,
  input wire logic sync_mode_i,
  input wire logic [1:0] led_mode_i,
  input wire logic aui_mode_i,
  input wire logic system_clock_20m_i,
  input wire logic backplane_clock_i,
  input wire logic serial_clk_i,
  input wire logic serial_setup_input_i,
  input wire logic chain_enable_in_n_i,
  input wire logic status_event_i,
  input wire logic [`SETUP_MSB:0] status_word_i,
  output logic serial_clk_o,
  output logic serial_clk_oe_n_o,
  output logic eeprom_cs_o,
  output logic rts_o,
  output logic chain_enable_out_n_o,
  output logic status_o,
  output logic status_oe_n_o,
  output logic mgmt_external_o,
  output logic first_position_o,
  output logic sync_mode_o,
  output logic [1:0] led_mode_o,
  output logic aui_mode_o,
  output logic setup_loaded_o,
  output loader_pkg::load_state_t load_state_o,
  output logic [`ALL_PORTS-1:0] autopart_off_o,
  output logic [`TP_PORTS-1:0] linktest_off_o,
  output logic [`TP_PORTS-1:0] polarity_fix_off_o,
  output logic [`ALL_PORTS-1:0] port_tx_off_o,
  output logic [`ALL_PORTS-1:0] port_rx_off_o,
  output logic [`TP_PORTS-1:0] low_squelch_on_o,
  output logic long_packet_guard_on_o,
  output logic code_violation_collide_off_o,
  output logic heartbeat_off_o,
  output logic frame_end_polarity_off_o,
  output logic fifo_error_collide_off_o,
  output logic lockup_counter_off_o
);
  import loader_pkg::*;

  load_state_t state_q;
  load_state_t state_d;
  logic [`RST_CNT_W-1:0] hw_cnt_q;
  logic hw_rec_q;
  logic ext_q;
  logic first_q;
  logic sync_q;
  logic [1:0] led_q;
  logic aui_q;
  logic drive_q;
  logic cs_q;
  logic rts_q;
  logic [`RTS_MSB:0] rts_sh_q;
  logic [3:0] rts_cnt_q;
  logic [5:0] bit_cnt_q;
  logic [`SETUP_MSB:0] shift_q;
  logic [`SETUP_MSB:0] setup_q;
  logic loaded_q;
  logic chain_out_n_q;
  logic sclk_in_q;
  logic st_busy_q;
  logic [5:0] st_cnt_q;
  logic [`SETUP_MSB:0] st_sh_q;
  logic st_out_q;
  logic st_oe_n_q;
  logic div_sclk;
  logic div_rise;
  logic div_fall;

  // =====================================================
  // reset pin qualification
  wire [`RST_CNT_W-1:0] rst_target_w = `RST_CNT_W'(RESET_MIN_CYCLES);
  wire hw_at_target_w = (hw_cnt_q == rst_target_w);
  // short pulses on the pin are glitches and never reach the loader
  wire clear_w = hw_reset_i & hw_rec_q;
  wire start_w = ~hw_reset_i & hw_rec_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hw_cnt_q <= '0;
      hw_rec_q <= 1'b0;
    end else begin
      if (!hw_reset_i) hw_cnt_q <= '0;
      else if (!hw_at_target_w) hw_cnt_q <= hw_cnt_q + 1'b1;
      if (start_w) hw_rec_q <= 1'b0;
      else if (hw_reset_i && hw_at_target_w) hw_rec_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_q <= 1'b0;
      first_q <= 1'b0;
      sync_q <= 1'b0;
      led_q <= 2'h0;
      aui_q <= 1'b0;
    end else if (start_w) begin
      ext_q <= ~mgmt_mode_select_i;
      first_q <= chain_first_select_i;
      sync_q <= sync_mode_i;
      led_q <= led_mode_i;
      aui_q <= aui_mode_i;
    end
  end

  // =====================================================
  // shift clock source and edges
  // position and management mode decide clock role
  wire first_local_w = first_q & ~ext_q;
  wire ext_rise_w = serial_clk_i & ~sclk_in_q;
  wire ext_fall_w = ~serial_clk_i & sclk_in_q;
  wire rise_w = drive_q ? div_rise : ext_rise_w;
  wire fall_w = drive_q ? div_fall : ext_fall_w;

  serial_clock_divider u_div (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(drive_q),
    .sync_mode_i(sync_q),
    .system_clock_20m_i(system_clock_20m_i),
    .backplane_clock_i(backplane_clock_i),
    .sclk_o(div_sclk),
    .sclk_rise_o(div_rise),
    .sclk_fall_o(div_fall)
  );

  // clock keeps running after own load: later devices still need it
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_q <= 1'b0;
      cs_q <= 1'b0;
      sclk_in_q <= 1'b0;
    end else begin
      sclk_in_q <= serial_clk_i;
      if (clear_w) begin
        drive_q <= 1'b0;
        cs_q <= 1'b0;
      end else if (start_w) begin
        drive_q <= chain_first_select_i & mgmt_mode_select_i;
        cs_q <= chain_first_select_i & mgmt_mode_select_i;
      end
    end
  end

  // =====================================================
  // load sequencer
  // chained device samples only while enabled
  wire sdi_en_w = first_local_w | ~chain_enable_in_n_i;
  wire take_w = (state_q == ST_CAPTURE) & rise_w & sdi_en_w;
  wire commit_w = take_w & (bit_cnt_q == `SETUP_LAST);
  // first bit lands in bit 0
  wire [`SETUP_MSB:0] shift_d = {serial_setup_input_i, shift_q[`SETUP_MSB:1]};

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_w) state_d = (chain_first_select_i & mgmt_mode_select_i) ? ST_RTS : ST_WAIT_EN;
      end
      ST_RTS: begin
        if (fall_w && rts_cnt_q == `RTS_BITS) state_d = ST_CAPTURE;
      end
      ST_WAIT_EN: begin
        if (!chain_enable_in_n_i) state_d = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        if (commit_w) state_d = ST_DONE;
      end
      ST_DONE: begin
        if (ext_q && chain_enable_in_n_i) state_d = ST_WAIT_EN;
      end
      default: state_d = ST_IDLE;
    endcase
    if (clear_w) state_d = ST_IDLE;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // request strobe, bits change on falling edges
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rts_q <= 1'b0;
      rts_sh_q <= '0;
      rts_cnt_q <= 4'h0;
    end else if (state_q != ST_RTS) begin
      rts_q <= 1'b0;
      rts_sh_q <= `RTS_PATTERN;
      rts_cnt_q <= 4'h0;
    end else if (fall_w && rts_cnt_q != `RTS_BITS) begin
      rts_q <= rts_sh_q[`RTS_MSB];
      rts_sh_q <= {rts_sh_q[`RTS_MSB-1:0], 1'b0};
      rts_cnt_q <= rts_cnt_q + 4'h1;
    end else if (fall_w) begin
      rts_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt_q <= 6'h0;
      shift_q <= '0;
    end else if (state_q != ST_CAPTURE) begin
      bit_cnt_q <= 6'h0;
    end else if (take_w) begin
      bit_cnt_q <= commit_w ? 6'h0 : (bit_cnt_q + 6'h1);
      shift_q <= shift_d;
    end
  end

  // word committed whole, so a partial load never shows
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setup_q <= '0;
      loaded_q <= 1'b0;
      chain_out_n_q <= 1'b1;
    end else if (clear_w) begin
      setup_q <= '0;
      loaded_q <= 1'b0;
      chain_out_n_q <= 1'b1;
    end else if (commit_w) begin
      setup_q <= shift_d;
      loaded_q <= 1'b1;
      chain_out_n_q <= 1'b0;
    end
  end

  // =====================================================
  // status burst, external mode only
  // events during a burst are dropped, not queued
  wire st_load_w = status_event_i & ext_q & loaded_q & ~st_busy_q;
  wire st_end_w = st_busy_q & ext_fall_w & (st_cnt_q == `STATUS_LAST);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_busy_q <= 1'b0;
      st_cnt_q <= 6'h0;
      st_sh_q <= '0;
      st_out_q <= 1'b0;
      st_oe_n_q <= 1'b1;
    end else if (clear_w || st_end_w) begin
      st_busy_q <= 1'b0;
      st_out_q <= 1'b0;
      st_oe_n_q <= 1'b1;
    end else if (st_load_w) begin
      st_busy_q <= 1'b1;
      st_cnt_q <= 6'h0;
      st_sh_q <= status_word_i;
      st_out_q <= status_word_i[0];
      st_oe_n_q <= 1'b0;
    end else if (st_busy_q && ext_fall_w) begin
      st_cnt_q <= st_cnt_q + 6'h1;
      st_sh_q <= {1'b0, st_sh_q[`SETUP_MSB:1]};
      st_out_q <= st_sh_q[1];
    end
  end

  // =====================================================
  // outputs
  assign serial_clk_o = div_sclk;
  assign serial_clk_oe_n_o = ~drive_q;
  assign eeprom_cs_o = cs_q;
  assign rts_o = rts_q;
  assign chain_enable_out_n_o = chain_out_n_q;
  assign status_o = st_out_q;
  assign status_oe_n_o = st_oe_n_q;
  assign mgmt_external_o = ext_q;
  assign first_position_o = first_q;
  assign sync_mode_o = sync_q;
  assign led_mode_o = led_q;
  assign aui_mode_o = aui_q;
  assign setup_loaded_o = loaded_q;
  assign load_state_o = state_q;

  assign autopart_off_o = setup_q[`AP_LSB +: `ALL_PORTS];
  // link test, ports 1 to 4
  assign linktest_off_o = {setup_q[`LT4_BIT], setup_q[`LT13_LSB +: `LT13_W]};
  assign polarity_fix_off_o = setup_q[`PRC_LSB +: `TP_PORTS];
  assign port_tx_off_o = setup_q[`TX_LSB +: `ALL_PORTS];
  assign port_rx_off_o = setup_q[`RX_LSB +: `ALL_PORTS];
  assign low_squelch_on_o = setup_q[`SQ_LSB +: `TP_PORTS];
  assign long_packet_guard_on_o = setup_q[`RXJAB_BIT];
  assign code_violation_collide_off_o = setup_q[`MCV_BIT];
  assign fifo_error_collide_off_o = setup_q[`FIFOE_BIT];
  assign heartbeat_off_o = setup_q[`SQE_BIT];
  assign frame_end_polarity_off_o = setup_q[`PFRM_BIT];
  assign lockup_counter_off_o = setup_q[`MJLP_BIT];

  // =====================================================
  // checks
  property p_local_quiet;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !ext_q |-> status_oe_n_o;
  endproperty
  a_local_quiet: assert property (p_local_quiet)
    else $error("status driven in local mode");

  property p_status_ext;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(status_oe_n_o) |-> ext_q && loaded_q && $past(status_event_i);
  endproperty
  a_status_ext: assert property (p_status_ext)
    else $error("status burst without external mode event");

  property p_reset_len;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(hw_rec_q) |-> $past(hw_reset_i) && $past(hw_cnt_q) == rst_target_w;
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("reset recognised too early");

  property p_clk_owner;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $changed(serial_clk_o) |-> !serial_clk_oe_n_o && first_q && !ext_q;
  endproperty
  a_clk_owner: assert property (p_clk_owner)
    else $error("shift clock toggles on non-first device");

  property p_cs_capture;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (state_q == ST_CAPTURE && first_local_w) |-> eeprom_cs_o && !serial_clk_oe_n_o;
  endproperty
  a_cs_capture: assert property (p_cs_capture)
    else $error("memory not selected during load");

  property p_rts_len;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (state_q == ST_RTS ##1 state_q == ST_CAPTURE) |-> $past(rts_cnt_q) == `RTS_BITS;
  endproperty
  a_rts_len: assert property (p_rts_len)
    else $error("request strobe not nine bits");

  property p_word_len;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (state_q == ST_CAPTURE ##1 state_q == ST_DONE) |-> $past(bit_cnt_q) == `SETUP_LAST && loaded_q;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("setup word not 48 bits");

  property p_pass_on;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(chain_enable_out_n_o) |-> state_q == ST_DONE && $past(state_q) == ST_CAPTURE;
  endproperty
  a_pass_on: assert property (p_pass_on)
    else $error("chain enable dropped outside load end");

  property p_sdi_gate;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (!first_local_w && state_q == ST_CAPTURE && $past(state_q) == ST_CAPTURE
        && bit_cnt_q != $past(bit_cnt_q)) |-> $past(chain_enable_in_n_i) == 1'b0;
  endproperty
  a_sdi_gate: assert property (p_sdi_gate)
    else $error("bit taken while chain enable high");

  property p_burst_len;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      ($rose(status_oe_n_o) && !$past(clear_w)) |-> $past(st_cnt_q) == `STATUS_LAST;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("status burst not 48 bits");

  property p_setup_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (!commit_w && !clear_w) |=> $stable(setup_q);
  endproperty
  a_setup_hold: assert property (p_setup_hold)
    else $error("setup word changed outside load");
endmodule : chained_setup_serial_loader

// ---- logic/loader_cfg.svh ----
// constants for the chained setup serial loader
`ifndef LOADER_CFG_SVH
`define LOADER_CFG_SVH

// =====================================================
// clocks and times
`define CLK_FREQ_HZ 200000000
`define RESET_MIN_MS 1
`define RESET_MIN_CYCLES (`RESET_MIN_MS * (`CLK_FREQ_HZ / 1000))
`define RST_CNT_W 18
`define SYSTEM_CLOCK_20M_HZ 20000000
`define BCLK_HZ 10000000
`define SCLK_HZ 1000000
`define DIV_LAST_ASYNC 4'(`SYSTEM_CLOCK_20M_HZ / `SCLK_HZ / 2 - 1)
`define DIV_LAST_SYNC 4'(`BCLK_HZ / `SCLK_HZ / 2 - 1)

// =====================================================
// serial framing
`define SETUP_BITS 48
`define SETUP_MSB 47
`define SETUP_LAST 6'd47
`define STATUS_LAST 6'd47
`define RTS_BITS 4'd9
`define RTS_MSB 8
`define RTS_PATTERN 9'h180

// =====================================================
// setup register field positions
`define TP_PORTS 4
`define ALL_PORTS 5
`define LT13_W 3
`define AP_LSB 0
`define LT13_LSB 5
`define LT4_BIT 8
`define PRC_LSB 9
`define TX_LSB 13
`define RX_LSB 18
`define SQ_LSB 23
`define RXJAB_BIT 27
`define MCV_BIT 28
`define SQE_BIT 29
`define PFRM_BIT 30
`define FIFOE_BIT 31
`define MJLP_BIT 32

`endif

// ---- logic/loader_pkg.sv ----
// types shared by the chained setup serial loader
package loader_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RTS,
    ST_WAIT_EN,
    ST_CAPTURE,
    ST_DONE
  } load_state_t;
endpackage : loader_pkg

// ---- logic/serial_clock_divider.sv ----
// divides the system or backplane clock down to the serial shift clock
`timescale 1ns/1ps
`include "loader_cfg.svh"

module serial_clock_divider (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic sync_mode_i,
  input wire logic system_clock_20m_i,
  input wire logic backplane_clock_i,
  output logic sclk_o,
  output logic sclk_rise_o,
  output logic sclk_fall_o
);
  import loader_pkg::*;

  logic src_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic sclk_q;
  logic rise_q;
  logic fall_q;

  // =====================================================
  // source selection and edge detect
  wire src_w = sync_mode_i ? backplane_clock_i : system_clock_20m_i;
  wire src_rise_w = src_w & ~src_q;
  wire [3:0] last_w = sync_mode_i ? `DIV_LAST_SYNC : `DIV_LAST_ASYNC;
  wire wrap_w = enable_i & src_rise_w & (cnt_q == last_w);
  assign cnt_d = wrap_w ? 4'h0 : (cnt_q + 4'h1);

  // half period counted in source edges, so jitter of the source carries through
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_q <= 1'b0;
      cnt_q <= 4'h0;
      sclk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      src_q <= src_w;
      if (enable_i && src_rise_w) cnt_q <= cnt_d;
      else if (!enable_i) cnt_q <= 4'h0; // stale count would stretch the first half period
      if (wrap_w) sclk_q <= ~sclk_q;
      rise_q <= wrap_w & ~sclk_q;
      fall_q <= wrap_w & sclk_q;
    end
  end

  assign sclk_o = sclk_q;
  assign sclk_rise_o = rise_q;
  assign sclk_fall_o = fall_q;
endmodule : serial_clock_divider

// ---- testbench/chained_setup_serial_loader_bench.sv ----
// self-checking bench for the chained setup serial loader
`timescale 1ns/1ps
`include "loader_cfg.svh"

module chained_setup_serial_loader_bench;
  import loader_pkg::*;
  // =====================================================
  // stimulus and wiring
  // reserved upper bits kept zero
  localparam logic [47:0] WORD_A = 48'h0000_d3a5_6c1b;
  localparam logic [47:0] WORD_B = 48'h0000_2c5a_93e4;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, hw_reset_i = 1'b0, mgmt_mode_select_i = 1'b1;
  logic chain_first_select_i = 1'b1, aui_mode_i = 1'b1, system_clock_20m_i = 1'b0, chain_enable_in_n_i = 1'b1;
  logic [1:0] led_mode_i = 2'b10;
  logic sync_mode_i = 1'b0, backplane_clock_i = 1'b0, status_event_i = 1'b0, bclk_run = 1'b1;
  logic [47:0] status_word_i = 48'h0;
  int half_cyc = 100;
  logic bench_phase = 1'b0, sclk_drv = 1'b0, sdi_drv = 1'b0;
  logic serial_clk_o, serial_clk_oe_n_o, eeprom_cs_o, rts_o, chain_enable_out_n_o, status_o, status_oe_n_o;
  logic mgmt_external_o, first_position_o, sync_mode_o, aui_mode_o, setup_loaded_o, mem_sdi;
  logic [1:0] led_mode_o;
  load_state_t load_state_o;
  logic [4:0] autopart_off_o, port_tx_off_o, port_rx_off_o;
  logic [3:0] linktest_off_o, polarity_fix_off_o, low_squelch_on_o;
  logic long_packet_guard_on_o, code_violation_collide_off_o, heartbeat_off_o;
  logic frame_end_polarity_off_o, fifo_error_collide_off_o, lockup_counter_off_o;
  logic [8:0] rts_seen;
  int errors = 0;
  int total_checks = 0;
  int sys_cnt = 0;
  // shift clock wire: bench plays the upstream repeater in the chained phase
  wire sclk_bus = bench_phase ? sclk_drv : (~serial_clk_oe_n_o & serial_clk_o);
  wire sdi_bus = bench_phase ? sdi_drv : mem_sdi;
  wire [32:0] fields = {lockup_counter_off_o, fifo_error_collide_off_o, frame_end_polarity_off_o,
    heartbeat_off_o, code_violation_collide_off_o, long_packet_guard_on_o, low_squelch_on_o,
    port_rx_off_o, port_tx_off_o, polarity_fix_off_o, linktest_off_o, autopart_off_o};

  chained_setup_serial_loader #(.RESET_MIN_CYCLES(8)) uut (
    .core_clk_i, .reset_n_i, .hw_reset_i, .mgmt_mode_select_i, .chain_first_select_i, .sync_mode_i,
    .led_mode_i, .aui_mode_i, .system_clock_20m_i, .backplane_clock_i, .serial_clk_i(sclk_bus),
    .serial_setup_input_i(sdi_bus), .chain_enable_in_n_i, .status_event_i, .status_word_i,
    .serial_clk_o, .serial_clk_oe_n_o, .eeprom_cs_o, .rts_o, .chain_enable_out_n_o, .status_o,
    .status_oe_n_o, .mgmt_external_o, .first_position_o, .sync_mode_o, .led_mode_o, .aui_mode_o,
    .setup_loaded_o, .load_state_o, .autopart_off_o, .linktest_off_o, .polarity_fix_off_o,
    .port_tx_off_o, .port_rx_off_o, .low_squelch_on_o, .long_packet_guard_on_o,
    .code_violation_collide_off_o, .heartbeat_off_o, .frame_end_polarity_off_o,
    .fifo_error_collide_off_o, .lockup_counter_off_o);

  setup_memory_model #(.STREAM({WORD_B, WORD_A})) mem (.core_clk_i, .reset_n_i, .sclk_i(sclk_bus),
    .cs_i(eeprom_cs_o), .rts_i(rts_o), .sdi_o(mem_sdi), .rts_seen_o(rts_seen));

  // 200 MHz core clock, 20 MHz source toggled off the sampling edge
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) begin
    sys_cnt <= (sys_cnt + 1) % 5;
    if (sys_cnt == 4) system_clock_20m_i <= ~system_clock_20m_i;
    // backplane at half the system rate, can be frozen to prove the source choice
    if (sys_cnt == 4 && !system_clock_20m_i && bclk_run) backplane_clock_i <= ~backplane_clock_i;
  end

  // =====================================================
  // shared tasks
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic hw_pulse(input int n);
    hw_reset_i = 1'b1;
    repeat (n) @(negedge core_clk_i);
    hw_reset_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask : hw_pulse

  // one upstream bit: data set while clock low, taken on the rise
  task automatic send_bit(input logic b);
    sdi_drv = b;
    repeat (half_cyc) @(negedge core_clk_i);
    sclk_drv = 1'b1;
    repeat (half_cyc) @(negedge core_clk_i);
    sclk_drv = 1'b0;
  endtask : send_bit

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // =====================================================
  // scenarios
  task automatic test_reset_and_short_pulse;
    check("chain out", chain_enable_out_n_o, 1'b1);
    check("fields", fields, 33'h0);
    hw_pulse(5);
    check("state", load_state_o, ST_IDLE);
    check("cs", eeprom_cs_o, 1'b0);
  endtask : test_reset_and_short_pulse

  task automatic test_external_latch;
    int i;
    mgmt_mode_select_i = 1'b0;
    hw_pulse(20);
    check("external", mgmt_external_o, 1'b1);
    check("clock drive", serial_clk_oe_n_o, 1'b1);
    check("cs", eeprom_cs_o, 1'b0);
    // manager supplies the 10 MHz shift clock
    half_cyc = 10;
    bench_phase = 1'b1;
    chain_enable_in_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    for (i = 0; i < 48; i++) send_bit(WORD_A[i]);
    check("ext fields", fields, WORD_A[32:0]);
    check("ext chain out", chain_enable_out_n_o, 1'b0);
    // status word goes out bit 0 first, one bit per supplied fall
    status_word_i = WORD_B;
    status_event_i = 1'b1;
    @(negedge core_clk_i);
    status_event_i = 1'b0;
    for (i = 0; i < 48; i++) begin
      check("status bit", {status_oe_n_o, status_o}, {1'b0, WORD_B[i]});
      send_bit(1'b0);
      @(negedge core_clk_i);
    end
    check("status done", status_oe_n_o, 1'b1);
    chain_enable_in_n_i = 1'b1;
    bench_phase = 1'b0;
    half_cyc = 100;
    mgmt_mode_select_i = 1'b1;
  endtask : test_external_latch

  task automatic test_sync_clock;
    int cyc;
    logic held;
    sync_mode_i = 1'b1;
    hw_pulse(20);
    check("sync", sync_mode_o, 1'b1);
    for (cyc = 0; cyc < 400 && serial_clk_o !== 1'b0; cyc++) @(negedge core_clk_i);
    for (cyc = 0; cyc < 400 && serial_clk_o !== 1'b1; cyc++) @(negedge core_clk_i);
    for (cyc = 0; cyc < 400 && serial_clk_o !== 1'b0; cyc++) @(negedge core_clk_i);
    for (; cyc < 400 && serial_clk_o !== 1'b1; cyc++) @(negedge core_clk_i);
    check("sync shift period", cyc, 200);
    // a frozen backplane must freeze the shift clock in sync mode
    bclk_run = 1'b0;
    held = serial_clk_o;
    repeat (400) @(negedge core_clk_i);
    check("sync source", serial_clk_o, held);
    bclk_run = 1'b1;
    sync_mode_i = 1'b0;
  endtask : test_sync_clock

  task automatic test_first_load;
    int k;
    int cyc;
    hw_pulse(20);
    check("pins", {first_position_o, mgmt_external_o, led_mode_o, aui_mode_o}, 5'b10101);
    check("cs", eeprom_cs_o, 1'b1);
    check("clock drive", serial_clk_oe_n_o, 1'b0);
    for (k = 0; k < 400 && serial_clk_o !== 1'b0; k++) @(negedge core_clk_i);
    for (k = 0; k < 400 && serial_clk_o !== 1'b1; k++) @(negedge core_clk_i);
    for (cyc = 0; cyc < 400 && serial_clk_o !== 1'b0; cyc++) @(negedge core_clk_i);
    for (; cyc < 400 && serial_clk_o !== 1'b1; cyc++) @(negedge core_clk_i);
    check("shift period", cyc, 200);
    for (k = 0; k < 20000 && chain_enable_out_n_o !== 1'b0; k++) @(negedge core_clk_i);
    check("request", rts_seen, `RTS_PATTERN);
    check("fields", fields, WORD_A[32:0]);
    check("loaded", setup_loaded_o, 1'b1);
    repeat (3000) @(negedge core_clk_i);
    check("fields held", fields, WORD_A[32:0]);
    check("chain out", chain_enable_out_n_o, 1'b0);
  endtask : test_first_load

  task automatic test_chained_load;
    int i;
    chain_first_select_i = 1'b0;
    bench_phase = 1'b1;
    hw_pulse(20);
    check("first", first_position_o, 1'b0);
    check("clock drive", serial_clk_oe_n_o, 1'b1);
    check("fields", fields, 33'h0);
    for (i = 0; i < 3; i++) send_bit(1'b1);
    check("loaded", setup_loaded_o, 1'b0);
    chain_enable_in_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    for (i = 0; i < 47; i++) begin
      // rises while enable is high are skipped
      if (i == 20) begin
        chain_enable_in_n_i = 1'b1;
        repeat (3) send_bit(1'b1);
        chain_enable_in_n_i = 1'b0;
      end
      send_bit(WORD_B[i]);
    end
    check("chain out", chain_enable_out_n_o, 1'b1);
    send_bit(WORD_B[47]);
    check("chain out", chain_enable_out_n_o, 1'b0);
    check("fields", fields, WORD_B[32:0]);
  endtask : test_chained_load

  // watchdog cuts a hang short
  initial begin
    repeat (100000) @(posedge core_clk_i);
    errors++;
    $display("mismatch watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    repeat (6) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    @(negedge core_clk_i);
    test_reset_and_short_pulse();
    test_external_latch();
    test_first_load();
    test_sync_clock();
    test_chained_load();
    stop_test();
  end
endmodule : chained_setup_serial_loader_bench

// ---- testbench/setup_memory_model.sv ----
// serial setup memory model answering the request strobe
`timescale 1ns/1ps

module setup_memory_model #(
  parameter logic [95:0] STREAM = 96'h0
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_i,
  input wire logic rts_i,
  output logic sdi_o,
  output logic [8:0] rts_seen_o
);
  // =====================================================
  // edge detect and stream
  logic sclk_q;
  logic [7:0] falls_q;
  wire rise = sclk_i & ~sclk_q;
  wire fall = ~sclk_i & sclk_q;

  // deselected line wanders so stale data never looks valid
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
      falls_q <= 8'h00;
      sdi_o <= 1'b0;
      rts_seen_o <= 9'h000;
    end else begin
      sclk_q <= sclk_i;
      if (!cs_i) begin
        falls_q <= 8'h00;
        sdi_o <= ~sdi_o;
      end else begin
        if (rise && falls_q >= 8'h01 && falls_q <= 8'h09) begin
          rts_seen_o <= {rts_seen_o[7:0], rts_i};
        end
        if (fall) begin
          falls_q <= falls_q + 8'h01;
          if (falls_q >= 8'h09 && falls_q < 8'h69) begin
            sdi_o <= STREAM[falls_q - 8'h09];
          end else begin
            sdi_o <= ~sdi_o;
          end
        end
      end
    end
  end
endmodule : setup_memory_model
